// [hw/hct_pkg.sv]
package hct_pkg;

  // Register port geometry
  localparam int HCT_AW = 4;
  localparam int HCT_DW = 16;

  // Register indices (word addresses on the register port)
  localparam logic [3:0] HCT_REG_CTRL = 4'h0;
  localparam logic [3:0] HCT_REG_HAC_EDGES = 4'h1;
  localparam logic [3:0] HCT_REG_RG1_EDGES = 4'h2;
  localparam logic [3:0] HCT_REG_RG2_EDGES = 4'h3;
  localparam logic [3:0] HCT_REG_SAMPLE_POS = 4'h4;
  localparam logic [3:0] HCT_REG_DRIVE = 4'h5;
  localparam logic [3:0] HCT_REG_LINE_LEN = 4'h6;
  localparam logic [3:0] HCT_REG_BLANK_BASE = 4'h7;
  localparam logic [3:0] HCT_REG_STATUS = 4'hD;
  localparam int HCT_NUM_CFG = 13;
  localparam int HCT_NUM_BLANK = 3;

  // Control register bits
  localparam int HCT_CTRL_EN_BIT = 0;
  localparam int HCT_CTRL_LEVEL_BIT = 1;
  localparam int HCT_CTRL_POL_HAC_BIT = 2;
  localparam int HCT_CTRL_POL_RG1_BIT = 3;
  localparam int HCT_CTRL_POL_RG2_BIT = 4;

  // Position field layout: rise or reference in low byte, fall or data high
  localparam int HCT_FIELD_W = 6;
  localparam int HCT_RISE_LSB = 0;
  localparam int HCT_FALL_LSB = 8;

  // Drive register layout
  localparam int HCT_DRV_H_LSB = 0;
  localparam int HCT_DRV_H_W = 4;
  localparam int HCT_DRV_RG_LSB = 4;
  localparam int HCT_DRV_RG_W = 3;
  localparam int HCT_DRV_HL_LSB = 8;
  localparam int HCT_DRV_HL_W = 3;

  // Status register layout
  localparam int HCT_ST_POS_LSB = 0;
  localparam int HCT_ST_IDX_LSB = 8;
  localparam int HCT_ST_BLANK_BIT = 10;
  localparam int HCT_ST_DONE_BIT = 11;

  // Pixel period split into edge positions, in quadrants
  localparam int HCT_POS_PER_PIXEL = 48;
  localparam logic [5:0] HCT_POS_LAST = 6'h2F;
  localparam logic [3:0] HCT_QUAD_SIZE = 4'hC;

  // Reset values and writable bits per configuration register
  localparam logic [15:0] HCT_RST_VAL [HCT_NUM_CFG] = '{
    16'h0000, 16'h2000, 16'h1000, 16'h1000, 16'h0820, 16'h0000,
    16'h0100, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h0000};
  localparam logic [15:0] HCT_WMASK [HCT_NUM_CFG] = '{
    16'h001F, 16'h3F3F, 16'h3F3F, 16'h3F3F, 16'h3F3F, 16'h077F,
    16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF,
    16'hFFFF};

  typedef enum logic [1:0] {
    HCT_WAIT,
    HCT_BLANK,
    HCT_DONE
  } hct_blank_e;

  // Quadrant code to linear edge position: quadrant * 12 + offset
  function automatic logic [5:0] hct_decode(input logic [5:0] code);
    logic [5:0] base;
    base = {1'b0, code[5:4], 3'b000} + {2'b00, code[5:4], 2'b00};
    return base + {2'b00, code[3:0]};
  endfunction : hct_decode

  // Offsets 12 to 15 never match any position
  function automatic logic hct_code_valid(input logic [5:0] code);
    return code[3:0] < HCT_QUAD_SIZE;
  endfunction : hct_code_valid

endpackage : hct_pkg

// [hw/hct_edge_gen.sv]
`timescale 1ns/1ns
module hct_edge_gen
  import hct_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic run,
  input wire logic [5:0] pos,
  input wire logic [5:0] rise_code,
  input wire logic [5:0] fall_code,
  output logic raw
);

  wire logic hit_rise;
  wire logic hit_fall;
  wire logic next_raw;

  // Invalid codes are ignored so a bad field cannot glitch the clock
  assign hit_rise = run && hct_code_valid(rise_code) &&
                    (pos == hct_decode(rise_code));
  assign hit_fall = run && hct_code_valid(fall_code) &&
                    (pos == hct_decode(fall_code));
  // Equal positions: rise wins, so the output goes high and then stays high
  assign next_raw = hit_rise ? 1'b1 : (hit_fall ? 1'b0 : raw);

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      raw <= 1'b0;
    end else begin
      raw <= next_raw;
    end
  end

endmodule : hct_edge_gen

// [hw/hct_timing.sv]
// Overview of operation
// - Polarity bit per A/C, reset gate one and two: zero passes, one inverts.
// - Six-bit field places rising edge of A/C and each reset gate clock.
// - Separate six-bit field places falling edge of those same clocks.
// - Reference and data sample strobes each placed by own six-bit field.
// - Four-bit drive code 0 to 15 for horizontal outputs, 4.3 mA steps.
// - Three-bit drive code 0 to 7 for reset gate outputs, 2.2 mA steps.
// - Three-bit drive code 0 to 7 for last-stage output, 2.2 mA steps.
// - Field upper two bits pick quadrant of twelve, lower bits the offset.
// - Each blanking interval is shaped only by its start and stop toggles.
// - Blanking with level bit set: A and C high, B and D low.
// - During blanking B is opposite A; level bit clear gives A low.
// - Three blanking intervals per line, handled in order from zero.
// - Each pixel period is split into 48 equal edge positions.
// - B and D are always the inverse of A and C.
// - Drive code zero disables the driver, leaving the output undriven.
`timescale 1ns/1ns
module hct_timing
  import hct_pkg::*;
#(
  parameter int LINE_W = 16
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [HCT_AW-1:0] reg_addr,
  input wire logic [HCT_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [HCT_DW-1:0] reg_rdata,
  output logic horiz_clock_a,
  output logic horiz_clock_b,
  output logic horiz_clock_c,
  output logic horiz_clock_d,
  output logic last_stage_horiz_clock,
  output logic reset_gate_clock_one,
  output logic reset_gate_clock_two,
  output logic reference_sample_strobe,
  output logic data_sample_strobe,
  output logic horizontal_blanking,
  output logic [HCT_DRV_H_W-1:0] horiz_drive_code,
  output logic [HCT_DRV_RG_W-1:0] reset_gate_drive_code,
  output logic [HCT_DRV_HL_W-1:0] last_stage_drive_code,
  output logic horiz_oe,
  output logic reset_gate_oe,
  output logic last_stage_oe
);

  // Configuration storage, one word per index
  logic [HCT_DW-1:0] cfg [HCT_NUM_CFG];

  // Timing state
  logic [5:0] pos;
  logic [LINE_W-1:0] pixel;
  hct_blank_e bstate;
  logic [1:0] bidx;

  // Delayed strobe stage keeps strobes aligned with the clock outputs
  logic ref_hit_d;
  logic data_hit_d;

  // Edge generator outputs before polarity
  logic hac_raw;
  logic rg1_raw;
  logic rg2_raw;

  // Register views
  wire logic [HCT_DW-1:0] ctrl;
  wire logic [HCT_DW-1:0] sample_pos;
  wire logic [HCT_DW-1:0] drive;
  wire logic [LINE_W-1:0] line_len;
  wire logic run;
  wire logic level;
  wire logic pol_hac;
  wire logic pol_rg1;
  wire logic pol_rg2;

  assign ctrl = cfg[HCT_REG_CTRL];
  assign sample_pos = cfg[HCT_REG_SAMPLE_POS];
  assign drive = cfg[HCT_REG_DRIVE];
  assign line_len = cfg[HCT_REG_LINE_LEN][LINE_W-1:0];
  assign run = ctrl[HCT_CTRL_EN_BIT];
  assign level = ctrl[HCT_CTRL_LEVEL_BIT];
  assign pol_hac = ctrl[HCT_CTRL_POL_HAC_BIT];
  assign pol_rg1 = ctrl[HCT_CTRL_POL_RG1_BIT];
  assign pol_rg2 = ctrl[HCT_CTRL_POL_RG2_BIT];

  // Register write decode
  genvar gi;
  generate
    for (gi = 0; gi < HCT_NUM_CFG; gi++) begin : g_cfg
      wire logic sel;
      assign sel = reg_wr && (reg_addr == 4'(gi));
      always_ff @(posedge clk) begin
        if (!rst_b) begin
          cfg[gi] <= HCT_RST_VAL[gi];
        end else if (sel) begin
          cfg[gi] <= reg_wdata & HCT_WMASK[gi];
        end
      end
    end
  endgenerate

  // Read path: status shows the live sequencer, unmapped reads give zero
  wire logic [HCT_DW-1:0] status;
  wire logic addr_is_cfg;
  wire logic addr_is_status;
  wire logic [HCT_DW-1:0] read_value;

  assign status = {4'h0,
                   (bstate == HCT_DONE),
                   (bstate == HCT_BLANK),
                   bidx,
                   2'b00,
                   pos};
  assign addr_is_cfg = reg_addr < 4'(HCT_NUM_CFG);
  assign addr_is_status = reg_addr == HCT_REG_STATUS;
  assign read_value = addr_is_cfg ? cfg[reg_addr] :
                      (addr_is_status ? status : 16'h0000);

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      reg_rdata <= read_value;
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // Edge position counter: one clock per forty-eighth of a pixel
  wire logic pixel_end;
  wire logic [5:0] next_pos;

  assign pixel_end = run && (pos == HCT_POS_LAST);
  assign next_pos = !run ? 6'h00 :
                    (pixel_end ? 6'h00 : pos + 6'h01);

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pos <= 6'h00;
    end else begin
      pos <= next_pos;
    end
  end

  // Pixel counter along the line; zero length is treated as one pixel
  wire logic last_pixel;
  wire logic line_wrap;
  wire logic [LINE_W-1:0] next_pixel;

  assign last_pixel = (line_len == '0) ||
                      (pixel == line_len - LINE_W'(1));
  assign line_wrap = pixel_end && last_pixel;
  assign next_pixel = !run ? '0 :
                      (line_wrap ? '0 :
                      (pixel_end ? pixel + LINE_W'(1) : pixel));

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pixel <= '0;
    end else begin
      pixel <= next_pixel;
    end
  end

  // Blanking sequencer: toggles are compared at pixel boundaries only
  wire logic [LINE_W-1:0] blank_start;
  wire logic [LINE_W-1:0] blank_stop;
  wire logic [3:0] start_index;
  wire logic [3:0] stop_index;
  hct_blank_e cur_state;
  hct_blank_e next_bstate;
  logic [1:0] cur_idx;
  logic [1:0] next_bidx;

  always_comb begin
    // Line start restarts with interval zero before any toggle check
    cur_state = line_wrap ? HCT_WAIT : bstate;
    cur_idx = line_wrap ? 2'b00 : bidx;
  end

  assign start_index = HCT_REG_BLANK_BASE + {1'b0, cur_idx, 1'b0};
  assign stop_index = start_index + 4'h1;
  assign blank_start = cfg[start_index][LINE_W-1:0];
  assign blank_stop = cfg[stop_index][LINE_W-1:0];

  always_comb begin
    next_bstate = bstate;
    next_bidx = bidx;
    if (!run) begin
      next_bstate = HCT_WAIT;
      next_bidx = 2'b00;
    end else if (pixel_end) begin
      next_bstate = cur_state;
      next_bidx = cur_idx;
      // Only the two toggles of the current interval matter
      unique case (cur_state)
        HCT_WAIT: begin
          if (next_pixel == blank_start) begin
            next_bstate = HCT_BLANK;
          end
        end
        HCT_BLANK: begin
          if (next_pixel == blank_stop) begin
            if (cur_idx == 2'(HCT_NUM_BLANK - 1)) begin
              next_bstate = HCT_DONE;
            end else begin
              next_bstate = HCT_WAIT;
              next_bidx = cur_idx + 2'b01;
            end
          end
        end
        HCT_DONE: begin
          next_bstate = HCT_DONE;
        end
        default: begin
          next_bstate = HCT_WAIT;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      bstate <= HCT_WAIT;
      bidx <= 2'b00;
    end else begin
      bstate <= next_bstate;
      bidx <= next_bidx;
    end
  end

  // Programmable clock waveforms
  hct_edge_gen u_hac (
    .clk(clk),
    .rst_b(rst_b),
    .run(run),
    .pos(pos),
    .rise_code(cfg[HCT_REG_HAC_EDGES][HCT_RISE_LSB +: HCT_FIELD_W]),
    .fall_code(cfg[HCT_REG_HAC_EDGES][HCT_FALL_LSB +: HCT_FIELD_W]),
    .raw(hac_raw)
  );

  hct_edge_gen u_rg1 (
    .clk(clk),
    .rst_b(rst_b),
    .run(run),
    .pos(pos),
    .rise_code(cfg[HCT_REG_RG1_EDGES][HCT_RISE_LSB +: HCT_FIELD_W]),
    .fall_code(cfg[HCT_REG_RG1_EDGES][HCT_FALL_LSB +: HCT_FIELD_W]),
    .raw(rg1_raw)
  );

  hct_edge_gen u_rg2 (
    .clk(clk),
    .rst_b(rst_b),
    .run(run),
    .pos(pos),
    .rise_code(cfg[HCT_REG_RG2_EDGES][HCT_RISE_LSB +: HCT_FIELD_W]),
    .fall_code(cfg[HCT_REG_RG2_EDGES][HCT_FALL_LSB +: HCT_FIELD_W]),
    .raw(rg2_raw)
  );

  // Sample strobes
  wire logic [5:0] ref_code;
  wire logic [5:0] data_code;
  wire logic ref_hit;
  wire logic data_hit;

  assign ref_code = sample_pos[HCT_RISE_LSB +: HCT_FIELD_W];
  assign data_code = sample_pos[HCT_FALL_LSB +: HCT_FIELD_W];
  assign ref_hit = run && hct_code_valid(ref_code) &&
                   (pos == hct_decode(ref_code));
  assign data_hit = run && hct_code_valid(data_code) &&
                    (pos == hct_decode(data_code));

  // Output shaping
  wire logic blanking;
  wire logic hac_level;

  assign blanking = bstate == HCT_BLANK;
  // Blanking overrides the waveform; polarity applies only outside it
  assign hac_level = blanking ? level : (hac_raw ^ pol_hac);

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      horiz_clock_a <= 1'b0;
      horiz_clock_b <= 1'b1;
      horiz_clock_c <= 1'b0;
      horiz_clock_d <= 1'b1;
      last_stage_horiz_clock <= 1'b0;
      reset_gate_clock_one <= 1'b0;
      reset_gate_clock_two <= 1'b0;
      ref_hit_d <= 1'b0;
      data_hit_d <= 1'b0;
      reference_sample_strobe <= 1'b0;
      data_sample_strobe <= 1'b0;
      horizontal_blanking <= 1'b0;
    end else begin
      horiz_clock_a <= hac_level;
      horiz_clock_c <= hac_level;
      horiz_clock_b <= ~hac_level;
      horiz_clock_d <= ~hac_level;
      last_stage_horiz_clock <= hac_level;
      reset_gate_clock_one <= rg1_raw ^ pol_rg1;
      reset_gate_clock_two <= rg2_raw ^ pol_rg2;
      ref_hit_d <= ref_hit;
      data_hit_d <= data_hit;
      reference_sample_strobe <= ref_hit_d;
      data_sample_strobe <= data_hit_d;
      horizontal_blanking <= blanking;
    end
  end

  // Drive strength codes; the pad turns the code into current
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      horiz_drive_code <= '0;
      reset_gate_drive_code <= '0;
      last_stage_drive_code <= '0;
    end else begin
      horiz_drive_code <= drive[HCT_DRV_H_LSB +: HCT_DRV_H_W];
      reset_gate_drive_code <= drive[HCT_DRV_RG_LSB +: HCT_DRV_RG_W];
      last_stage_drive_code <= drive[HCT_DRV_HL_LSB +: HCT_DRV_HL_W];
    end
  end

  // Zero code turns the driver off
  assign horiz_oe = horiz_drive_code != '0;
  assign reset_gate_oe = reset_gate_drive_code != '0;
  assign last_stage_oe = last_stage_drive_code != '0;

endmodule : hct_timing

// [dv/hct_sensor_model.sv]
`timescale 1ns/1ns
module hct_sensor_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic horiz_clock_a,
  input wire logic horiz_oe,
  output int shift_count
);
  logic last_a;
  // A floating phase pin moves no charge, so it shifts nothing
  always @(posedge clk) begin
    if (!rst_b) begin
      shift_count <= 0;
      last_a <= 1'h0;
    end else begin
      last_a <= horiz_clock_a;
      if (horiz_oe && horiz_clock_a && !last_a) begin
        shift_count <= shift_count + 1;
      end
    end
  end
endmodule : hct_sensor_model

// [dv/hct_timing_asserts.sv]
`timescale 1ns/1ns
module hct_timing_asserts
  import hct_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [HCT_AW-1:0] reg_addr,
  input wire logic [HCT_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [HCT_DW-1:0] reg_rdata,
  input wire logic horiz_clock_a,
  input wire logic horiz_clock_b,
  input wire logic horiz_clock_c,
  input wire logic horiz_clock_d,
  input wire logic last_stage_horiz_clock,
  input wire logic reference_sample_strobe,
  input wire logic horizontal_blanking,
  input wire logic [HCT_DRV_H_W-1:0] horiz_drive_code,
  input wire logic [HCT_DRV_RG_W-1:0] reset_gate_drive_code,
  input wire logic [HCT_DRV_HL_W-1:0] last_stage_drive_code,
  input wire logic horiz_oe,
  input wire logic reset_gate_oe,
  input wire logic last_stage_oe
);
  logic lvl;
  wire ctrl_wr = reg_wr && reg_addr == HCT_REG_CTRL;
  wire drv_wr = reg_wr && reg_addr == HCT_REG_DRIVE;
  wire [15:0] drv = {5'h00, last_stage_drive_code, 1'h0,
    reset_gate_drive_code, horiz_drive_code};
  always_ff @(posedge clk) begin
    if (!rst_b) lvl <= 1'h0;
    else if (ctrl_wr) lvl <= reg_wdata[HCT_CTRL_LEVEL_BIT];
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  pair_inverse_a: assert property (
    horiz_clock_b == !horiz_clock_a && horiz_clock_d == !horiz_clock_c)
    else $error("b or d not inverse of a or c");
  ac_follow_a: assert property (
    horiz_clock_c == horiz_clock_a && last_stage_horiz_clock == horiz_clock_a)
    else $error("c or last stage differs from a");
  drive_oe_a: assert property (
    horiz_oe == (horiz_drive_code != '0) && last_stage_oe ==
    (last_stage_drive_code != '0) && reset_gate_oe ==
    (reset_gate_drive_code != '0)) else $error("enable not tied to code");
  drive_write_a: assert property (
    drv_wr |-> ##2 drv == ($past(reg_wdata, 2) & 16'h077F))
    else $error("drive codes not updated");
  drive_readback_a: assert property (
    drv_wr ##1 reg_rd && reg_addr == HCT_REG_DRIVE
    |=> reg_rdata == ($past(reg_wdata, 2) & 16'h077F))
    else $error("drive readback wrong");
  rdata_idle_a: assert property (!reg_rd |=> reg_rdata == '0)
    else $error("read data without read");
  blank_level_a: assert property (
    horizontal_blanking && lvl == $past(lvl) |-> horiz_clock_a == lvl)
    else $error("blanking level wrong");
  strobe_pulse_a: assert property (
    $rose(reference_sample_strobe) |=> !reference_sample_strobe [*8])
    else $error("strobe not a single pulse");
  reset_state_a: assert property (disable iff (1'h0)
    !rst_b |=> !horiz_clock_a && horiz_clock_b && reg_rdata == '0)
    else $error("reset state wrong");
endmodule : hct_timing_asserts

bind hct_timing hct_timing_asserts u_hct_timing_asserts (
  .clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .horiz_clock_a(horiz_clock_a), .horiz_clock_b(horiz_clock_b),
  .horiz_clock_c(horiz_clock_c), .horiz_clock_d(horiz_clock_d),
  .last_stage_horiz_clock(last_stage_horiz_clock),
  .reference_sample_strobe(reference_sample_strobe),
  .horizontal_blanking(horizontal_blanking),
  .horiz_drive_code(horiz_drive_code),
  .reset_gate_drive_code(reset_gate_drive_code),
  .last_stage_drive_code(last_stage_drive_code), .horiz_oe(horiz_oe),
  .reset_gate_oe(reset_gate_oe), .last_stage_oe(last_stage_oe)
);

// [dv/hct_timing_tb.sv]
`timescale 1ns/1ns
module hct_timing_tb;
  import hct_pkg::*;
  logic clk, rst_b, reg_wr, reg_rd;
  logic [3:0] reg_addr, hdrv;
  logic [15:0] reg_wdata, reg_rdata;
  logic ha, hb, hc, hd, hl, rg1, rg2, rs, ds, blk, hoe, rgoe, hloe;
  logic ha_q, rg_q, r2_q, blk_q, lv;
  logic [2:0] rgdrv, hldrv;
  logic [15:0] bpos [6] = '{16'h0001, 16'h0002, 16'h0003, 16'h0005,
    16'h0006, 16'h0007};
  int mismatches, samples_checked, shifts, s0, b0, u0, ar, af;
  int cyc, t_ar, t_af, t_rg, t_r2, t_rs, t_ds, bl_hi, bl_up, bad;

  hct_timing #(.LINE_W(16)) u_hct_timing (.clk(clk), .rst_b(rst_b),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .horiz_clock_a(ha),
    .horiz_clock_b(hb), .horiz_clock_c(hc), .horiz_clock_d(hd),
    .last_stage_horiz_clock(hl), .reset_gate_clock_one(rg1),
    .reset_gate_clock_two(rg2), .reference_sample_strobe(rs),
    .data_sample_strobe(ds), .horizontal_blanking(blk),
    .horiz_drive_code(hdrv), .reset_gate_drive_code(rgdrv),
    .last_stage_drive_code(hldrv), .horiz_oe(hoe), .reset_gate_oe(rgoe),
    .last_stage_oe(hloe));
  hct_sensor_model u_hct_sensor_model (.clk(clk), .rst_b(rst_b),
    .horiz_clock_a(ha), .horiz_oe(hoe), .shift_count(shifts));

  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    ha_q <= ha;
    rg_q <= rg1;
    r2_q <= rg2;
    blk_q <= blk;
    if (ha && !ha_q) t_ar <= cyc;
    if (!ha && ha_q) t_af <= cyc;
    if (!rg1 && rg_q) t_rg <= cyc;
    if (rg2 && !r2_q) t_r2 <= cyc;
    if (rs) t_rs <= cyc;
    if (ds) t_ds <= cyc;
    if (blk) bl_hi <= bl_hi + 1;
    if (blk && !blk_q) bl_up <= bl_up + 1;
    if (blk && (ha !== lv || hb !== !lv)) bad <= bad + 1;
  end

  function automatic int ph(input int a, input int b);
    return ((a - b) % HCT_POS_PER_PIXEL + HCT_POS_PER_PIXEL)
      % HCT_POS_PER_PIXEL;
  endfunction : ph

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_rd <= 1'h0;
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk);
    reg_wr <= 1'h0;
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'h0;
    #1 chk(reg_rdata, exp);
  endtask : rd

  task automatic idle(input int n);
    @(posedge clk);
    reg_wr <= 1'h0;
    repeat (n) @(posedge clk);
  endtask : idle

  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : test_done

  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    $display("[ERR] %0t watchdog expired", $time);
    test_done();
  end

  initial begin
    {rst_b, reg_wr, reg_rd, reg_addr, reg_wdata, lv} = '0;
    repeat (3) @(posedge clk);
    rst_b <= 1'h1;
    for (int i = 0; i < HCT_NUM_CFG; i++) rd(4'(i), HCT_RST_VAL[i]);
    rd(4'hE, 16'h0000);
    // Level bit clear, every position offset kept below twelve
    for (int i = 0; i < HCT_NUM_CFG; i++) begin
      wr(4'(i), 16'hFBF9);
      rd(4'(i), HCT_WMASK[i] & 16'hFBF9);
    end
    chk({hdrv, rgdrv, hldrv, hoe, rgoe, hloe, 3'h0}, 16'h9EF8);
    $display("register test done");
    for (int p = 0; p < 2; p++) begin
      wr(HCT_REG_CTRL, 16'h0000);
      wr(HCT_REG_BLANK_BASE, 16'hFFFF);
      wr(HCT_REG_HAC_EDGES, 16'h2B10);
      wr(HCT_REG_RG1_EDGES, 16'h003B);
      wr(HCT_REG_RG2_EDGES, 16'h2005);
      wr(HCT_REG_SAMPLE_POS, 16'h301B);
      wr(HCT_REG_DRIVE, 16'h0777);
      wr(HCT_REG_CTRL, p ? 16'h001D : 16'h0009);
      idle(200);
      ar = p ? 35 : 12;
      af = p ? 12 : 35;
      chk(16'(ph(t_af, t_ar)), 16'(ph(af, ar)));
      chk(16'(ph(t_rg, t_ar)), 16'(ph(47, ar)));
      chk(16'(ph(t_r2, t_ar)), 16'(ph(p ? 24 : 5, ar)));
      chk(16'(ph(t_rs, t_ar)), 16'(ph(23, ar)));
      chk(16'(ph(t_ds, t_ar)), 16'(ph(36, ar)));
      s0 = shifts;
      repeat (480) @(posedge clk);
      chk(16'(shifts - s0), 16'h000A);
    end
    wr(HCT_REG_DRIVE, 16'h0000);
    idle(2);
    s0 = shifts;
    repeat (96) @(posedge clk);
    chk({13'h0000, hoe, rgoe, hloe} | 16'(shifts - s0), 16'h0000);
    $display("edge test done");
    for (int l = 0; l < 2; l++) begin
      wr(HCT_REG_CTRL, 16'h0000);
      wr(HCT_REG_LINE_LEN, 16'h0008);
      for (int k = 0; k < 6; k++) begin
        wr(HCT_REG_BLANK_BASE + 4'(k), bpos[k]);
      end
      lv = l[0];
      wr(HCT_REG_CTRL, {14'h0000, lv, 1'h1});
      idle(340);
      rd(HCT_REG_STATUS, 16'h0A05);
      b0 = bl_hi;
      u0 = bl_up;
      repeat (768) @(posedge clk);
      chk(16'(bl_hi - b0), 16'(8 * HCT_POS_PER_PIXEL));
      chk(16'(bl_up - u0), 16'h0006);
    end
    chk(16'(bad), 16'h0000);
    $display("blanking test done");
    test_done();
  end
endmodule : hct_timing_tb
